// *** design/lhbp_fifo.sv ***
// fifo holding received bytes plus their data/command flag
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module lhbp_fifo
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;
  // handshakes; read data comes out of a register
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  // storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end
  // pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // registered head word; reloads after every pop or first push
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (!out_valid || pop)
    begin
      out_valid <= (count_ff > (AW+1)'(pop ? 1 : 0)) || 1'b0;
      out_data  <= mem_ff[pop ? ((rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1) : rd_ptr_ff];
    end
  end
endmodule : lhbp_fifo
`default_nettype wire

// *** design/lhbp_port.sv ***
// host bus port of a graphic display controller: 8080/6800 parallel and serial
// assumes host pins are asynchronous to SYS_CLK and get resynchronised here
`timescale 1ns/1ns
`default_nettype none
`include "lhbp_params.svh"
module lhbp_port
  import lhbp_pkg::*;
#(
  parameter int FIFO_DEPTH = `LHBP_FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  // bus style straps
  input  wire logic       MODE_6800,
  input  wire logic       MODE_SERIAL,
  // host pins
  input  wire logic       READ_STROBE_OR_ENABLE,
  input  wire logic       WRITE_STROBE_OR_DIRECTION,
  input  wire logic       DATA_COMMAND_SELECT,
  input  wire logic       INIT_LOW_INPUT_N,
  input  wire logic       SELECT_LOW_INPUT_N,
  input  wire logic       SELECT_HIGH_INPUT,
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE,
  // received stream to the core
  output logic            RX_VALID,
  input  wire logic       RX_READY,
  output logic      [7:0] RX_DATA,
  output logic            RX_IS_DISPLAY,
  // read data from the core; read end, overrun and init status to it
  input  wire logic [7:0] READ_DATA,
  output logic            READ_TAKEN,
  output logic            RX_OVERRUN,
  output logic            INIT_ACTIVE
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int NS = 14;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_ff;
  logic [NS-1:0] s2_ff;
  logic [NS-1:0] s3_ff;
  logic [NS-1:0] pin_ff;
  assign pin_raw = {READ_STROBE_OR_ENABLE, WRITE_STROBE_OR_DIRECTION, DATA_COMMAND_SELECT,
                    INIT_LOW_INPUT_N, SELECT_LOW_INPUT_N, SELECT_HIGH_INPUT, DATA_IN};
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      // idle levels, so leaving reset shows no false strobe and no false init
      s1_ff  <= `LHBP_PIN_IDLE;
      s2_ff  <= `LHBP_PIN_IDLE;
      s3_ff  <= `LHBP_PIN_IDLE;
      pin_ff <= `LHBP_PIN_IDLE;
    end
    else
    begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < NS; i++)
        if (s2_ff[i] == s3_ff[i])
          pin_ff[i] <= s3_ff[i];
    end
  end
  logic       rd_e;
  logic       wr_rw;
  logic       dc_sel;
  logic       init_n;
  logic       cs_ok;
  logic [7:0] din;
  assign rd_e   = pin_ff[13];
  assign wr_rw  = pin_ff[12];
  assign dc_sel = pin_ff[11];
  assign init_n = pin_ff[10];
  assign cs_ok  = !pin_ff[9] && pin_ff[8];
  assign din    = pin_ff[7:0];
  logic rd_e_q_ff;
  logic wr_q_ff;
  logic sclk_q_ff;
  logic init_hold;
  assign init_hold = RESET || !init_n; // level acts every cycle it is low
  // previous samples for edge detection, taken after the filter; they track the pins
  // during init as well, so an idle enable low in 6800 style gives no false edge
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      rd_e_q_ff <= 1'b1;
      wr_q_ff   <= 1'b1;
      sclk_q_ff <= 1'b0;
    end
    else
    begin
      rd_e_q_ff <= rd_e;
      wr_q_ff   <= wr_rw;
      sclk_q_ff <= din[6];
    end
  end
  // ------------------------------------------------------------
  // transfer decode
  // ------------------------------------------------------------
  logic wr8080_evt;
  logic wr6800_evt;
  logic ser_evt;
  logic rd_window;
  logic rd_end;
  assign wr8080_evt = !MODE_SERIAL && !MODE_6800 && cs_ok && wr_rw && !wr_q_ff;
  assign wr6800_evt = !MODE_SERIAL && MODE_6800 && cs_ok && !rd_e && rd_e_q_ff && !wr_rw;
  assign ser_evt    = MODE_SERIAL && cs_ok && din[6] && !sclk_q_ff;
  assign rd_window  = !MODE_SERIAL && cs_ok &&
                      (MODE_6800 ? (rd_e && wr_rw) : !rd_e);
  assign rd_end     = !MODE_SERIAL && (MODE_6800 ? (!rd_e && rd_e_q_ff && wr_rw) : (rd_e && !rd_e_q_ff));
  // ------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------
  logic [7:0] sh_ff;
  logic [2:0] bit_cnt_ff;
  logic       ser_done;
  assign ser_done = ser_evt && bit_cnt_ff == 3'h7;
  // msb first; deselect aborts a partial byte
  always_ff @(posedge SYS_CLK)
  begin
    if (init_hold || !cs_ok || !MODE_SERIAL)
    begin
      sh_ff      <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end
    else if (ser_evt)
    begin
      sh_ff      <= {sh_ff[6:0], din[7]};
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end
  // ------------------------------------------------------------
  // receive fifo
  // ------------------------------------------------------------
  logic       push;
  logic [8:0] push_word;
  logic       fifo_ready;
  logic       f_valid;
  logic [8:0] f_data;
  assign push      = wr8080_evt || wr6800_evt || ser_done;
  // flag travels with the byte so the core routes it
  assign push_word = ser_done ? {dc_sel, sh_ff[6:0], din[7]} : {dc_sel, din};
  lhbp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk       (SYS_CLK),
    .rst       (init_hold),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (f_valid),
    .out_ready (RX_READY && !RX_VALID || RX_READY),
    .out_data  (f_data)
  );
  // output registers toward the core; host cannot be stalled, so a full fifo flags overrun
  always_ff @(posedge SYS_CLK)
  begin
    if (init_hold)
    begin
      RX_VALID      <= 1'b0;
      RX_DATA       <= 8'h00;
      RX_IS_DISPLAY <= 1'b0;
      RX_OVERRUN    <= 1'b0;
      INIT_ACTIVE   <= 1'b1;
    end
    else
    begin
      RX_VALID      <= f_valid && RX_READY;
      RX_DATA       <= f_data[7:0];
      RX_IS_DISPLAY <= f_data[8];
      RX_OVERRUN    <= RX_OVERRUN || (push && !fifo_ready);
      INIT_ACTIVE   <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  lhbp_state_e state_ff;
  // bus driven only inside a qualified read window
  always_ff @(posedge SYS_CLK)
  begin
    if (init_hold)
    begin
      state_ff   <= LHBP_IDLE;
      DATA_OE    <= 1'b0;
      DATA_OUT   <= `LHBP_RD_INIT;
      READ_TAKEN <= 1'b0;
    end
    else
    begin
      READ_TAKEN <= rd_end && state_ff == LHBP_RD_ACT;
      unique case (state_ff)
        LHBP_IDLE, LHBP_WR_ACT:
        begin
          DATA_OE <= rd_window;
          DATA_OUT <= READ_DATA;
          state_ff <= rd_window ? LHBP_RD_ACT : LHBP_IDLE;
        end
        LHBP_RD_ACT:
        begin
          DATA_OE <= rd_window;
          if (!rd_window)
            state_ff <= LHBP_IDLE;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // an 8080 write: the filtered write strobe comes back high while selected
  sequence s_wr_edge;
    !MODE_SERIAL && !MODE_6800 && cs_ok && !wr_q_ff ##0 wr_rw;
  endsequence
  // a 6800 read window: enable high with the direction line high
  sequence s_e_read;
    !MODE_SERIAL && MODE_6800 && cs_ok && rd_e ##0 wr_rw;
  endsequence
  // a 6800 write ends on the falling enable with the direction line low
  sequence s_e_fall;
    !MODE_SERIAL && MODE_6800 && cs_ok && rd_e_q_ff ##0 !rd_e && !wr_rw;
  endsequence
  // a rising serial clock inside a selected frame
  sequence s_ser_clk_rise;
    MODE_SERIAL && cs_ok && !sclk_q_ff ##0 din[6];
  endsequence
  // bus direction
  a_oe_needs_select: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    DATA_OE |-> $past(cs_ok))
    else $error("bus driven while deselected");
  a_rd8080_drive: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    (!MODE_SERIAL && !MODE_6800 && cs_ok && !rd_e) |=> DATA_OE)
    else $error("8080 read not driven");
  a_rd6800_drive: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    (!MODE_SERIAL && MODE_6800 && !rd_e) |=> !DATA_OE)
    else $error("6800 drive outside enable");
  a_rd6800_window: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    s_e_read |=> DATA_OE)
    else $error("6800 read window not driven");
  a_write_no_drive: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    (MODE_6800 && !wr_rw) |=> !DATA_OE)
    else $error("driven during 6800 write");
  // write capture
  a_wr_edge_push: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    s_wr_edge |-> push)
    else $error("write edge not captured");
  a_e_fall_push: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    s_e_fall |-> push)
    else $error("6800 write not captured");
  a_no_push_desel: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    !cs_ok |-> !push)
    else $error("capture while deselected");
  a_dc_flag_kept: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    push |-> push_word[8] == dc_sel)
    else $error("data/command flag lost");
  // read handshake: the byte stands still while driven, and the bus is let go at the end
  a_read_data_held: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    (DATA_OE && $past(DATA_OE)) |-> $stable(DATA_OUT))
    else $error("read byte changed while driven");
  a_taken_release: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    READ_TAKEN |-> !DATA_OE)
    else $error("bus still driven after read end");
  a_taken_pulse: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    READ_TAKEN |=> !READ_TAKEN)
    else $error("read end longer than one cycle");
  // init
  a_init_clears: assert property (@(posedge SYS_CLK)
    init_hold |=> (!DATA_OE && !RX_VALID && INIT_ACTIVE && !RX_OVERRUN && !READ_TAKEN))
    else $error("init did not clear");
  a_init_filtered: assert property (@(posedge SYS_CLK)
    (!RESET && !s2_ff[10] && !s3_ff[10]) |=> init_hold)
    else $error("steady init level not acted on");
  a_ovr_sticky: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    RX_OVERRUN |=> RX_OVERRUN)
    else $error("overrun dropped without init");
  // serial
  a_serial_count: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    ser_done |-> (MODE_SERIAL && bit_cnt_ff == 3'h7))
    else $error("serial byte miscounted");
  a_ser_shift: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    s_ser_clk_rise |=> bit_cnt_ff == $past(bit_cnt_ff) + 3'h1)
    else $error("serial clock edge not counted");
  a_ser_push: assert property (@(posedge SYS_CLK) disable iff (init_hold)
    s_ser_clk_rise ##0 (bit_cnt_ff == 3'h7) |-> (push && push_word[0] == din[7]))
    else $error("eighth serial bit not stored");
endmodule : lhbp_port
`default_nettype wire

// *** inc/lhbp_params.svh ***
// constants for the display host bus port: sync depth, fifo size, pin idle levels
// assumes inclusion by bare name from the package and design files
`ifndef LHBP_PARAMS_SVH
`define LHBP_PARAMS_SVH
`define LHBP_DATA_W      8
`define LHBP_FIFO_DEPTH  16
`define LHBP_SER_BITS    8
`define LHBP_SYNC_STAGES 3
`define LHBP_RD_INIT     8'h00
// idle levels of the synchronised pins: read, write, dc, init, select_n, select, data
`define LHBP_PIN_IDLE    14'h3600
`endif

// *** inc/lhbp_pkg.sv ***
// types shared by the display host bus port
// assumes lhbp_params.svh is on the include path
`include "lhbp_params.svh"
package lhbp_pkg;
  typedef enum logic [1:0] {LHBP_IDLE, LHBP_WR_ACT, LHBP_RD_ACT} lhbp_state_e;
  typedef logic [`LHBP_DATA_W-1:0] lhbp_byte_t;
endpackage : lhbp_pkg

// *** testbench/lhbp_host_model.sv ***
// host processor model driving the display port pins
// assumes the bench resolves the shared data bus
`timescale 1ns/1ns
`default_nettype none
module lhbp_host_model
(
  // clock and style
  input  wire logic       clk,
  input  wire logic       m6800,
  // host pins
  output logic            re,
  output logic            we,
  output logic            dc,
  output logic            cs_n,
  output logic            cs_h,
  output logic            init_n,
  output logic      [7:0] d
);
  // ----
  // pin tasks
  // ----
  // pins move 10 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step
  // strobes inactive, chip deselected
  task automatic idle();
    re   = !m6800;
    we   = 1'b1;
    cs_n = 1'b1;
    cs_h = 1'b0;
  endtask : idle
  // init level held by the caller
  task automatic set_init(input logic v);
    init_n = v;
  endtask : set_init
  // one parallel transfer; sel is {cs_n, cs_h}
  task automatic xfer(input logic rd, input logic a, input logic [7:0] v, input logic [1:0] sel);
    {cs_n, cs_h} = sel;
    dc = a;
    d  = rd ? ~d : v; // released bus shows the inverse
    if (m6800)
    begin
      we = rd;
      step(2);
      re = 1'b1;
      step(6);
      re = 1'b0;
    end
    else
    begin
      re = !rd;
      we = rd;
      step(6);
      re = 1'b1;
      we = 1'b1;
    end
    step(4);
    idle();
    step(6);
  endtask : xfer
  // serial byte msb first; clock stands low outside frames
  task automatic ser(input logic a, input logic [7:0] v);
    cs_n = 1'b0;
    cs_h = 1'b1;
    dc   = a;
    d[6] = 1'b0;
    step(4);
    for (int i = 7; i >= 0; i--)
    begin
      d[7] = v[i];
      step(5);
      d[6] = 1'b1;
      step(5);
      d[6] = 1'b0;
    end
    step(4);
    idle();
    step(6);
  endtask : ser
  // quiet host at time zero
  initial
  begin
    init_n = 1'b1;
    dc     = 1'b0;
    d      = 8'h00;
    idle();
  end
endmodule : lhbp_host_model
`default_nettype wire

// *** testbench/tb_lcd_host_bus_port.sv ***
// self-checking bench for the display host bus port
// assumes lhbp_host_model plays the host processor
`timescale 1ns/1ns
`default_nettype none
`include "lhbp_params.svh"
module tb_lcd_host_bus_port
  import lhbp_pkg::*;
;
  localparam int DEPTH = `LHBP_FIFO_DEPTH;
  logic       clk      = 1'b0;
  logic       rst      = 1'b1;
  logic       m6800    = 1'b0;
  logic       mser     = 1'b0;
  logic       rx_ready = 1'b1;
  lhbp_byte_t rd_data  = 8'h96;
  lhbp_byte_t oe_data, dout, rxd, hd;
  logic       re, we, dc, cs_n, cs_h, init_n;
  logic       oe, rxv, rxdisp, taken, ovr, iact;
  wire  [7:0] bus;
  int         err_count, check_count, oe_cnt, taken_cnt;
  logic [8:0] rxq[$];
  // wire level: the port wins while it drives
  assign bus = oe ? dout : hd;
  lhbp_host_model host_u (.clk(clk), .m6800(m6800), .re(re), .we(we), .dc(dc), .cs_n(cs_n),
    .cs_h(cs_h), .init_n(init_n), .d(hd));
  lhbp_port #(.FIFO_DEPTH(DEPTH)) dut_u (.SYS_CLK(clk), .RESET(rst), .MODE_6800(m6800),
    .MODE_SERIAL(mser), .READ_STROBE_OR_ENABLE(re), .WRITE_STROBE_OR_DIRECTION(we),
    .DATA_COMMAND_SELECT(dc), .INIT_LOW_INPUT_N(init_n), .SELECT_LOW_INPUT_N(cs_n),
    .SELECT_HIGH_INPUT(cs_h), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(oe), .RX_VALID(rxv),
    .RX_READY(rx_ready), .RX_DATA(rxd), .RX_IS_DISPLAY(rxdisp), .READ_DATA(rd_data),
    .READ_TAKEN(taken), .RX_OVERRUN(ovr), .INIT_ACTIVE(iact));
  // ----
  // clock, monitor, helpers
  // ----
  initial
  begin
    forever #50 clk = ~clk;
  end
  // collect popped bytes and drive activity
  always @(posedge clk)
  begin
    if (rxv === 1'b1) rxq.push_back({rxdisp, rxd});
    if (oe === 1'b1) oe_cnt++;
    if (oe === 1'b1) oe_data = dout;
    if (taken === 1'b1) taken_cnt++;
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : settle
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // switch bus style while deselected
  task automatic style(input logic m);
    m6800 = m;
    host_u.idle();
    settle(10);
    rxq.delete();
    oe_cnt = 0;
    taken_cnt = 0;
  endtask : style
  // ----
  // scenarios
  // ----
  // command then display byte, back to back
  task automatic t_write(input logic m);
    style(m);
    host_u.xfer(1'b0, 1'b0, 8'ha5, 2'b01);
    host_u.xfer(1'b0, 1'b1, 8'h3c, 2'b01);
    settle(10);
    check("rx count", 9'(rxq.size()), 9'd2);
    check("cmd byte", rxq[0], 9'h0a5);
    check("data byte", rxq[1], 9'h13c);
    check("no drive", 9'(oe_cnt), 9'd0);
  endtask : t_write
  task automatic t_read(input logic m);
    style(m);
    rd_data = m ? 8'h69 : 8'h96;
    host_u.xfer(1'b1, 1'b0, 8'h00, 2'b01);
    check("driven", 9'(oe_cnt > 0), 9'd1);
    check("read byte", {1'b0, oe_data}, {1'b0, rd_data});
    check("taken", 9'(taken_cnt), 9'd1);
    check("released", {8'h00, oe}, 9'h000);
  endtask : t_read
  // every half-selected or unselected combination
  task automatic t_desel();
    logic [1:0] sels[3] = '{2'b00, 2'b11, 2'b10};
    style(1'b0);
    foreach (sels[i])
    begin
      host_u.xfer(1'b0, 1'b1, 8'h11, sels[i]);
      host_u.xfer(1'b1, 1'b0, 8'h00, sels[i]);
    end
    settle(10);
    check("ignored rx", 9'(rxq.size()), 9'd0);
    check("ignored rd", 9'(oe_cnt), 9'd0);
  endtask : t_desel
  task automatic t_serial();
    mser = 1'b1;
    style(1'b0);
    host_u.ser(1'b1, 8'hc3);
    host_u.ser(1'b0, 8'h5a);
    settle(10);
    mser = 1'b0;
    check("ser count", 9'(rxq.size()), 9'd2);
    check("ser byte0", rxq[0], 9'h1c3);
    check("ser byte1", rxq[1], 9'h05a);
  endtask : t_serial
  // overfill with the core stalled, drain, then init
  task automatic t_full_init();
    style(1'b0);
    rx_ready = 1'b0;
    for (int i = 0; i < DEPTH + 2; i++) host_u.xfer(1'b0, 1'b1, 8'(i), 2'b01);
    check("overrun", {8'h00, ovr}, 9'h001);
    rx_ready = 1'b1;
    settle(40);
    check("drained", 9'(rxq.size()), 9'(DEPTH));
    check("last kept", rxq[DEPTH-1], 9'(9'h100 + DEPTH - 1));
    host_u.set_init(1'b0);
    settle(8);
    check("init held", {8'h00, iact}, 9'h001);
    check("ovr cleared", {8'h00, ovr}, 9'h000);
    host_u.xfer(1'b0, 1'b1, 8'h77, 2'b01);
    host_u.set_init(1'b1);
    settle(10);
    check("init done", {8'h00, iact}, 9'h000);
    check("init ignores", 9'(rxq.size()), 9'(DEPTH));
  endtask : t_full_init
  // reset 4 cycles, then every scenario
  initial
  begin
    settle(4);
    rst = 1'b0;
    settle(6);
    t_write(1'b0);
    t_write(1'b1);
    t_read(1'b0);
    t_read(1'b1);
    t_desel();
    t_serial();
    t_full_init();
    summarize();
  end
  // watchdog well past the expected 868 cycles
  initial
  begin
    #2000000;
    err_count++;
    summarize();
  end
endmodule : tb_lcd_host_bus_port
`default_nettype wire
